/* File: hw/cmp_ctrl_pkg.sv */
// package: register map, field layout and carriers for the comparator control block
package cmp_ctrl_pkg;

  localparam int unsigned NUM_CMP = 2;

  // wishbone byte offsets, one aligned word per register
  localparam logic [5:0] CONTROL_A1_OFF  = 6'h00;
  localparam logic [5:0] CONTROL_B1_OFF  = 6'h04;
  localparam logic [5:0] CONTROL_A2_OFF  = 6'h08;
  localparam logic [5:0] CONTROL_B2_OFF  = 6'h0C;
  localparam logic [5:0] MIRROR_OFF      = 6'h10;
  localparam logic [5:0] IRQ_STATUS_OFF  = 6'h14;
  localparam logic [5:0] IRQ_ENABLE_OFF  = 6'h18;
  localparam logic [5:0] IRQ_CLEAR_OFF   = 6'h1C;
  localparam logic [5:0] GATE_CFG_OFF    = 6'h20;

  // comparator_control_a field positions
  localparam int unsigned ENABLE_BIT  = 7;
  localparam int unsigned RESULT_BIT  = 6;
  localparam int unsigned INVERT_BIT  = 4;
  localparam int unsigned SPEED_BIT   = 2;
  localparam int unsigned HYST_BIT    = 1;
  localparam int unsigned SYNC_BIT    = 0;
  // comparator_control_b field positions
  localparam int unsigned RISE_BIT    = 7;
  localparam int unsigned FALL_BIT    = 6;
  localparam int unsigned PCH_LSB     = 3;
  localparam int unsigned NCH_LSB     = 0;
  // gate configuration: sleep bit and two-bit timer clock source
  localparam int unsigned SLEEP_BIT   = 0;
  localparam int unsigned SRC_LSB     = 1;

  // writable bits of control a, and reset values of control a and control b
  localparam logic [7:0] CONTROL_A_WMASK = 8'h97;
  localparam logic [7:0] CONTROL_A_RESET = 8'h04;
  localparam logic [7:0] CONTROL_B_RESET = 8'h00;

  // gate timer clock sources; system and instruction clocks stop in sleep
  typedef enum logic [1:0] {
    SRC_SYSTEM      = 2'h0,
    SRC_INSTRUCTION = 2'h1,
    SRC_EXTERNAL    = 2'h2,
    SRC_SECONDARY   = 2'h3
  } gate_src_t;

  // positive channel codes
  localparam logic [2:0] PCH_GROUND = 3'h7;
  localparam logic [2:0] PCH_REFBUF = 3'h6;
  localparam logic [2:0] PCH_DAC    = 3'h5;
  localparam logic [2:0] PCH_PIN0   = 3'h0;
  // negative channel codes
  localparam logic [2:0] NCH_GROUND = 3'h7;
  localparam logic [2:0] NCH_REFBUF = 3'h6;
  localparam logic [2:0] NCH_PIN3   = 3'h3;

  // one-hot analog routing per comparator
  typedef struct packed {
    logic       pos_ground;
    logic       pos_refbuf;
    logic       pos_dac;
    logic       pos_pin0;
    logic       neg_ground;
    logic       neg_refbuf;
    logic [3:0] neg_pin;
  } mux_sel_t;

  // analog front-end controls per comparator
  typedef struct packed {
    logic     enable;
    logic     hysteresis;
    logic     high_speed;
    mux_sel_t route;
  } analog_ctl_t;

  typedef struct packed {
    logic [NUM_CMP-1:0] data_lo;
  } unused_t;

endpackage : cmp_ctrl_pkg

/* File: hw/cmp_ctrl.sv */
// comparator control and status logic with wishbone register access
//
// Functional notes
// - synchronised output clocks on falling edges of the gate timer clock source.
// - in sleep with system or instruction timer clock, synchronised outputs freeze.
// - an enabled comparator interrupt raises a wake request during sleep.
// - enable bit 7 of control a, resets to zero; off gates the analog side.
// - read-only bit 6 reports the latched output after polarity.
// - bit 4 inverts the comparator output when set; resets to zero.
// - bit 1 enables input hysteresis; resets to zero.
// - with sync bit 0 set, timer and pin output change on timer clock falls.
// - with sync bit 0 clear, timer and pin output pass straight through.
// - control b bit 7 lets rising output edges set the interrupt flag.
// - control b bit 6 lets falling output edges set the interrupt flag.
// - positive field 5:3 selects ground, ref buffer, dac, pin 0 or none.
// - negative field 2:0 selects ground, ref buffer, none, or pins 3 to 0.
// - mirror register holds comparator 1 in bit 0, comparator 2 in bit 1.
// - internal output is latched once per instruction cycle.
// - software clears the flag; an edge in the clearing cycle keeps it set.
// - polarity or enable toggles can cause an interrupting edge even when off.
`timescale 1ns/10ps
`default_nettype none

module cmp_ctrl #(
  parameter int unsigned INSTR_DIV = 4
) (
  input  wire logic                            clk_i,
  input  wire logic                            rst_i,
  input  wire logic [5:0]                      wb_adr_i,
  input  wire logic [31:0]                     wb_dat_i,
  input  wire logic [3:0]                      wb_sel_i,
  input  wire logic                            wb_we_i,
  input  wire logic                            wb_cyc_i,
  input  wire logic                            wb_stb_i,
  output logic      [31:0]                     wb_dat_o,
  output logic                                 wb_ack_o,
  input  wire logic [cmp_ctrl_pkg::NUM_CMP-1:0] raw_compare_i,
  input  wire logic                            timer_clk_level_i,
  output logic      [cmp_ctrl_pkg::NUM_CMP-1:0] gate_out_o,
  output logic      [cmp_ctrl_pkg::NUM_CMP-1:0] pin_out_o,
  output cmp_ctrl_pkg::analog_ctl_t            analog_ctl_one_o,
  output cmp_ctrl_pkg::analog_ctl_t            analog_ctl_two_o,
  output logic                                 irq_o,
  output logic                                 wake_o
);

  // the divider is eight bits wide, so a longer instruction cycle cannot be counted
  if (INSTR_DIV < 1 || INSTR_DIV > 256) begin : g_bad_instr_div
    $error("INSTR_DIV out of range");
  end

  localparam int unsigned N = cmp_ctrl_pkg::NUM_CMP;

  typedef struct packed {
    logic [N-1:0][7:0]  control_a;
    logic [N-1:0][7:0]  control_b;
    logic [N-1:0]       latched;
    logic [N-1:0]       prev_latched;
    logic [N-1:0]       timer_sync;
    logic [N-1:0]       irq_flag;
    logic [N-1:0]       irq_en;
    logic [2:0]         gate_cfg;
    logic               timer_clk_prev;
    logic [7:0]         div_cnt;
    logic               ack;
    logic [31:0]        rdata;
    logic [N-1:0]       gate_out;
    logic [N-1:0]       pin_out;
    logic               irq;
    logic               wake;
    cmp_ctrl_pkg::analog_ctl_t [N-1:0] actl;
  } state_t;

  state_t state_reg;
  state_t state_next;

  function automatic cmp_ctrl_pkg::mux_sel_t decode_route(input logic [7:0] ctl_b);
    cmp_ctrl_pkg::mux_sel_t m;
    logic [2:0]             p;
    logic [2:0]             n;
    m = '0;
    p = ctl_b[cmp_ctrl_pkg::PCH_LSB +: 3];
    n = ctl_b[cmp_ctrl_pkg::NCH_LSB +: 3];
    m.pos_ground = (p == cmp_ctrl_pkg::PCH_GROUND);
    m.pos_refbuf = (p == cmp_ctrl_pkg::PCH_REFBUF);
    m.pos_dac    = (p == cmp_ctrl_pkg::PCH_DAC);
    m.pos_pin0   = (p == cmp_ctrl_pkg::PCH_PIN0);
    m.neg_ground = (n == cmp_ctrl_pkg::NCH_GROUND);
    m.neg_refbuf = (n == cmp_ctrl_pkg::NCH_REFBUF);
    if (n <= cmp_ctrl_pkg::NCH_PIN3) begin
      m.neg_pin = 4'h1 << n[1:0];
    end
    return m;
  endfunction : decode_route

  function automatic logic hit(input logic [5:0] a, input logic [5:0] off);
    return a[5:2] == off[5:2];
  endfunction : hit

  logic                   wb_req;
  logic                   wb_wr;
  logic [N-1:0]           polar;
  logic [N-1:0]           rise;
  logic [N-1:0]           fall;
  logic [N-1:0]           edge_hit;
  logic [N-1:0]           clear_mask;
  logic                   instr_tick;
  logic                   timer_fall;
  logic                   sync_frozen;
  logic [1:0]             src;

  always_comb begin
    state_next = state_reg;
    wb_req     = wb_cyc_i && wb_stb_i && !state_reg.ack;
    wb_wr      = wb_req && wb_we_i && wb_sel_i[0];
    clear_mask = '0;
    src        = state_reg.gate_cfg[cmp_ctrl_pkg::SRC_LSB +: 2];
    // system and instruction clocks stop in sleep, so the timer domain freezes
    sync_frozen = state_reg.gate_cfg[cmp_ctrl_pkg::SLEEP_BIT]
      && (src == cmp_ctrl_pkg::SRC_SYSTEM || src == cmp_ctrl_pkg::SRC_INSTRUCTION);
    timer_fall = state_reg.timer_clk_prev && !timer_clk_level_i && !sync_frozen;

    instr_tick = (state_reg.div_cnt == 8'(INSTR_DIV - 1));
    state_next.div_cnt = instr_tick ? 8'h00 : 8'(state_reg.div_cnt + 8'h01);
    state_next.timer_clk_prev = timer_clk_level_i;

    // register writes
    if (wb_wr) begin
      for (int i = 0; i < N; i++) begin
        if (hit(wb_adr_i, 6'(cmp_ctrl_pkg::CONTROL_A1_OFF + 6'(8 * i)))) begin
          state_next.control_a[i] = wb_dat_i[7:0] & cmp_ctrl_pkg::CONTROL_A_WMASK;
        end
        if (hit(wb_adr_i, 6'(cmp_ctrl_pkg::CONTROL_B1_OFF + 6'(8 * i)))) begin
          state_next.control_b[i] = wb_dat_i[7:0];
        end
      end
      if (hit(wb_adr_i, cmp_ctrl_pkg::IRQ_ENABLE_OFF)) begin
        state_next.irq_en = wb_dat_i[N-1:0];
      end
      if (hit(wb_adr_i, cmp_ctrl_pkg::IRQ_CLEAR_OFF)) begin
        clear_mask = wb_dat_i[N-1:0];
      end
      if (hit(wb_adr_i, cmp_ctrl_pkg::GATE_CFG_OFF)) begin
        state_next.gate_cfg = wb_dat_i[2:0];
      end
    end

    // polarity applies even while disabled, so enable or invert toggles can give an edge
    for (int i = 0; i < N; i++) begin
      polar[i] = (state_reg.control_a[i][cmp_ctrl_pkg::ENABLE_BIT] && raw_compare_i[i])
        ^ state_reg.control_a[i][cmp_ctrl_pkg::INVERT_BIT];
    end
    if (instr_tick) begin
      state_next.latched      = polar;
      state_next.prev_latched = state_reg.latched;
    end
    for (int i = 0; i < N; i++) begin
      rise[i] = state_reg.latched[i] && !state_reg.prev_latched[i];
      fall[i] = !state_reg.latched[i] && state_reg.prev_latched[i];
    end
    // edges are seen only in the cycle after a latch, so each is counted once
    for (int i = 0; i < N; i++) begin
      edge_hit[i] = state_reg.div_cnt == 8'h00
        && ((rise[i] && state_reg.control_b[i][cmp_ctrl_pkg::RISE_BIT])
         || (fall[i] && state_reg.control_b[i][cmp_ctrl_pkg::FALL_BIT]));
    end
    state_next.irq_flag = (state_reg.irq_flag & ~clear_mask) | edge_hit;

    // timer-synchronised copy updates only on source clock falls
    for (int i = 0; i < N; i++) begin
      if (timer_fall) begin
        state_next.timer_sync[i] = polar[i];
      end
      state_next.gate_out[i] = state_reg.control_a[i][cmp_ctrl_pkg::SYNC_BIT]
        ? state_next.timer_sync[i] : polar[i];
      state_next.actl[i].enable     = state_reg.control_a[i][cmp_ctrl_pkg::ENABLE_BIT];
      state_next.actl[i].hysteresis = state_reg.control_a[i][cmp_ctrl_pkg::HYST_BIT];
      state_next.actl[i].high_speed = state_reg.control_a[i][cmp_ctrl_pkg::SPEED_BIT];
      state_next.actl[i].route      = state_reg.control_a[i][cmp_ctrl_pkg::ENABLE_BIT]
        ? decode_route(state_reg.control_b[i]) : '0;
    end
    state_next.pin_out = state_next.gate_out;
    state_next.irq  = |(state_next.irq_flag & state_next.irq_en);
    state_next.wake = state_next.irq && state_reg.gate_cfg[cmp_ctrl_pkg::SLEEP_BIT];

    // read path; unmapped offsets read zero and still acknowledge
    state_next.ack   = wb_req;
    state_next.rdata = '0;
    if (wb_req && !wb_we_i) begin
      for (int i = 0; i < N; i++) begin
        if (hit(wb_adr_i, 6'(cmp_ctrl_pkg::CONTROL_A1_OFF + 6'(8 * i)))) begin
          state_next.rdata[7:0] = state_reg.control_a[i];
          state_next.rdata[cmp_ctrl_pkg::RESULT_BIT] = state_reg.latched[i];
        end
        if (hit(wb_adr_i, 6'(cmp_ctrl_pkg::CONTROL_B1_OFF + 6'(8 * i)))) begin
          state_next.rdata[7:0] = state_reg.control_b[i];
        end
      end
      if (hit(wb_adr_i, cmp_ctrl_pkg::MIRROR_OFF)) begin
        state_next.rdata[N-1:0] = state_reg.latched;
      end
      if (hit(wb_adr_i, cmp_ctrl_pkg::IRQ_STATUS_OFF)) begin
        state_next.rdata[N-1:0] = state_reg.irq_flag;
      end
      if (hit(wb_adr_i, cmp_ctrl_pkg::IRQ_ENABLE_OFF)) begin
        state_next.rdata[N-1:0] = state_reg.irq_en;
      end
      if (hit(wb_adr_i, cmp_ctrl_pkg::GATE_CFG_OFF)) begin
        state_next.rdata[2:0] = state_reg.gate_cfg;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= '0;
      for (int i = 0; i < N; i++) begin
        state_reg.control_a[i] <= cmp_ctrl_pkg::CONTROL_A_RESET;
        state_reg.control_b[i] <= cmp_ctrl_pkg::CONTROL_B_RESET;
      end
    end else begin
      state_reg <= state_next;
    end
  end

  assign wb_dat_o         = state_reg.rdata;
  assign wb_ack_o         = state_reg.ack;
  assign gate_out_o       = state_reg.gate_out;
  assign pin_out_o        = state_reg.pin_out;
  assign analog_ctl_one_o = state_reg.actl[0];
  assign analog_ctl_two_o = state_reg.actl[1];
  assign irq_o            = state_reg.irq;
  assign wake_o           = state_reg.wake;

endmodule : cmp_ctrl

`default_nettype wire

/* File: tb/cmp_ctrl_properties.sv */
// checker: bus answer and output timing assertions for the comparator block
`timescale 1ns/10ps
`default_nettype none
module cmp_ctrl_properties (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [5:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic        wb_we_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [1:0]  raw_compare_i,
  input wire logic        timer_clk_level_i,
  input wire logic [1:0]  gate_out_o,
  input wire logic [1:0]  pin_out_o,
  input wire logic        irq_o,
  input wire logic        wake_o
);
  // shadow of comparator one control a, so the output paths can be predicted
  logic [7:0] ctl_reg;
  logic       tclk_reg;
  logic [2:0] fall_age_reg;
  wire        take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        polar = (ctl_reg[7] & raw_compare_i[0]) ^ ctl_reg[4];
  wire        rd_ack = wb_ack_o & ~wb_we_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_reg      <= 8'h04;
      tclk_reg     <= 1'b0;
      fall_age_reg <= 3'h7;
    end else begin
      if (take && wb_we_i && wb_sel_i[0] && wb_adr_i[5:2] == 4'h0)
        ctl_reg <= wb_dat_i[7:0] & cmp_ctrl_pkg::CONTROL_A_WMASK;
      tclk_reg     <= timer_clk_level_i;
      // saturates so a long quiet timer never wraps back into the window
      fall_age_reg <= (tclk_reg && !timer_clk_level_i) ? 3'h0
                      : fall_age_reg + {2'h0, fall_age_reg != 3'h7};
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence seq_take;
    take;
  endsequence
  sequence seq_answer;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  chk_ack_one_pulse: assert property (seq_take |=> seq_answer)
    else $error("ack is not one pulse one cycle after the request");
  chk_rdata_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  chk_mirror_upper: assert property (rd_ack && wb_adr_i[5:2] == 4'h4 |->
    wb_dat_o[31:2] == 30'h0) else $error("mirror upper bits not zero");
  chk_ctla_read: assert property (rd_ack && wb_adr_i[5:2] == 4'h0 |->
    (wb_dat_o & 32'hFFFFFFBF) == {24'h0, ctl_reg}) else $error("control a readback wrong");
  chk_pin_gate: assert property (pin_out_o == gate_out_o)
    else $error("pin output differs from gate output");
  chk_async_follow: assert property (!ctl_reg[0] && !$past(ctl_reg[0]) |->
    gate_out_o[0] == $past(polar)) else $error("async output not one clock behind");
  chk_sync_fall: assert property (ctl_reg[0] && $past(ctl_reg[0], 2) &&
    $changed(gate_out_o[0]) |-> fall_age_reg <= 3'h3) else $error("sync output moved off a fall");
  chk_wake_irq: assert property (wake_o |-> irq_o || $past(irq_o))
    else $error("wake without interrupt");
endmodule : cmp_ctrl_properties

bind cmp_ctrl cmp_ctrl_properties chk (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
  .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .raw_compare_i,
  .timer_clk_level_i, .gate_out_o, .pin_out_o, .irq_o, .wake_o);
`default_nettype wire

/* File: tb/cmp_far_side.sv */
// far side model: analog comparison results and gate timer clock source
`timescale 1ns/10ps
`default_nettype none
module cmp_far_side (
  input  wire logic       clk_i,
  input  wire logic [1:0] target_i,
  input  wire logic [3:0] lag_i,
  input  wire logic       run_i,
  output logic      [1:0] raw_o,
  output logic            tclk_o
);
  logic [1:0] raw_reg  = 2'h0;
  logic [3:0] wait_reg = 4'h0;
  logic [1:0] div_reg  = 2'h0;
  logic       tclk_reg = 1'b0;
  assign raw_o  = raw_reg;
  assign tclk_o = tclk_reg;
  // result settles lag_i cycles late, like a slow analog response
  always @(posedge clk_i) begin
    wait_reg <= (raw_reg == target_i) ? lag_i : wait_reg - 4'h1;
    if (raw_reg != target_i && wait_reg == 4'h0)
      raw_reg <= target_i;
    div_reg <= run_i ? div_reg + 2'h1 : 2'h0;
    // timer source stands still while not running
    if (run_i && div_reg == 2'h2)
      tclk_reg <= ~tclk_reg;
  end
endmodule : cmp_far_side
`default_nettype wire

/* File: tb/cmp_ctrl_bench.sv */
// testbench: register, comparator path and interrupt scenarios for cmp_ctrl
`timescale 1ns/10ps
`default_nettype none
module cmp_ctrl_bench;
  localparam logic [5:0]  CA1 = cmp_ctrl_pkg::CONTROL_A1_OFF;
  localparam logic [5:0]  CB1 = cmp_ctrl_pkg::CONTROL_B1_OFF;
  localparam logic [5:0]  CA2 = cmp_ctrl_pkg::CONTROL_A2_OFF;
  localparam logic [5:0]  MIR = cmp_ctrl_pkg::MIRROR_OFF;
  localparam logic [5:0]  STS = cmp_ctrl_pkg::IRQ_STATUS_OFF;
  localparam logic [5:0]  IEN = cmp_ctrl_pkg::IRQ_ENABLE_OFF;
  localparam logic [5:0]  ICL = cmp_ctrl_pkg::IRQ_CLEAR_OFF;
  localparam logic [5:0]  GCF = cmp_ctrl_pkg::GATE_CFG_OFF;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [5:0] wb_adr_i = 6'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'hF;
  logic wb_we_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [1:0] raw_compare_i, gate_out_o, pin_out_o;
  logic timer_clk_level_i, irq_o, wake_o, g;
  cmp_ctrl_pkg::analog_ctl_t analog_ctl_one_o, analog_ctl_two_o;
  logic [1:0] target = 2'h0;
  logic [3:0] lag = 4'h0;
  logic run = 1'b0;
  int miscompares = 0;
  int checks = 0;
  logic [31:0] exp_q[$];
  logic [31:0] mask_q[$];

  always #2 clk_i = ~clk_i;

  cmp_ctrl uut (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i,
    .wb_stb_i, .wb_dat_o, .wb_ack_o, .raw_compare_i, .timer_clk_level_i, .gate_out_o,
    .pin_out_o, .analog_ctl_one_o, .analog_ctl_two_o, .irq_o, .wake_o);
  cmp_far_side far (.clk_i, .target_i(target), .lag_i(lag), .run_i(run),
    .raw_o(raw_compare_i), .tclk_o(timer_clk_level_i));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict

  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wt

  task automatic bus(input logic [5:0] a, input logic we, input logic [31:0] d,
    input logic [3:0] s = 4'hF);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_sel_i <= s;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : bus

  task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    mask_q.push_back(m);
    bus(a, 1'b0, 32'h0);
  endtask : rd

  // read results are matched in issue order as their acks appear
  always @(posedge clk_i)
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
      check("rdata", wb_dat_o & mask_q.pop_front(), exp_q.pop_front());

  // over forty times the expected run
  initial begin
    #100000;
    miscompares++;
    print_verdict();
  end

  initial begin
    void'($urandom(27284));
    wt(12);
    rst_i <= 1'b0;
    rd(CA1, 32'h04, ALL);
    rd(CB1, 32'h00, ALL);
    rd(MIR, 32'h00, ALL);
    bus(6'h24, 1'b1, 32'hFF);
    rd(6'h24, 32'h0, ALL);
    bus(CA1, 1'b1, 32'hFF);
    wt(8);
    rd(CA1, 32'hD7, ALL);
    bus(CA1, 1'b1, 32'h00, 4'hE);
    rd(CA1, 32'hD7, ALL);
    for (int i = 0; i < 4; i++) begin
      target <= {~i[1], i[1]};
      lag    <= 4'($urandom_range(4));
      bus(CA1, 1'b1, {24'h0, 3'h4, i[0], 4'h4});
      bus(CA2, 1'b1, {24'h0, 3'h4, i[0], 4'h4});
      wt(12);
      rd(CA1, {24'h0, 1'b1, i[1] ^ i[0], 1'b0, i[0], 4'h4}, ALL);
      rd(MIR, {30'h0, ~i[1] ^ i[0], i[1] ^ i[0]}, ALL);
    end
    bus(CA1, 1'b1, 32'h86);
    for (int i = 0; i < 8; i++) begin
      bus(CB1, 1'b1, {26'h0, i[2:0], i[2:0]});
      wt(2);
      check("route", {22'h0, analog_ctl_one_o.route}, {22'h0, i == 7, i == 6, i == 5, i == 0,
        i == 7, i == 6, 4'(i < 4 ? 1 << i : 0)});
    end
    check("ctl", analog_ctl_one_o[12:10], 3'h7);
    check("route2", analog_ctl_two_o.route, 10'h041);
    target <= 2'h0;
    bus(IEN, 1'b1, 32'h3);
    bus(CB1, 1'b1, 32'h80);
    wt(14);
    bus(ICL, 1'b1, 32'h3);
    target <= 2'h1;
    wt(14);
    check("irq", irq_o, 1'b1);
    rd(STS, 32'h1, ALL);
    bus(ICL, 1'b1, 32'h1);
    wt(2);
    check("irq", irq_o, 1'b0);
    target <= 2'h0;
    wt(14);
    check("irq", irq_o, 1'b0);
    bus(CB1, 1'b1, 32'h40);
    target <= 2'h1;
    wt(14);
    check("irq", irq_o, 1'b0);
    target <= 2'h0;
    wt(14);
    check("irq", irq_o, 1'b1);
    bus(CB1, 1'b1, 32'hC0);
    bus(CA1, 1'b1, 32'h04);
    wt(8);
    bus(ICL, 1'b1, 32'h1);
    bus(CA1, 1'b1, 32'h14);
    wt(10);
    check("irq", irq_o, 1'b1);
    bus(GCF, 1'b1, 32'h5);
    wt(3);
    check("wake", wake_o, 1'b1);
    bus(IEN, 1'b1, 32'h0);
    wt(3);
    check("wake", {irq_o, wake_o}, 2'h0);
    rd(STS, 32'h1, ALL);
    bus(GCF, 1'b1, 32'h0);
    bus(CA1, 1'b1, 32'h85);
    wt(8);
    g = gate_out_o[0];
    target <= 2'h1;
    wt(14);
    check("gate", gate_out_o[0], g);
    run <= 1'b1;
    wt(16);
    check("gate", gate_out_o[0], 1'b1);
    bus(GCF, 1'b1, 32'h1);
    target <= 2'h0;
    wt(16);
    check("gate", gate_out_o[0], 1'b1);
    bus(GCF, 1'b1, 32'h5);
    wt(16);
    check("gate", gate_out_o[0], 1'b0);
    run <= 1'b0;
    bus(CA1, 1'b1, 32'h84);
    for (int i = 0; i < 16; i++) begin
      target <= 2'($urandom);
      lag    <= 4'($urandom_range(3));
      wt(8);
    end
    print_verdict();
  end
endmodule : cmp_ctrl_bench
`default_nettype wire
